/* File: autoreload_pwm_pkg.sv */
// Constants for the auto-reload PWM timer core
package autoreload_pwm_pkg;
    localparam int CNT_W = 12;
    localparam logic [11:0] CNT_MAX = 12'hFFF;
    localparam logic [11:0] CNT_RST = 12'h000;
    localparam int SLOW_DIV = 32;
    localparam int PRE_W = $clog2(SLOW_DIV);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SLOW_DIV - 1);
    // Register index map
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_CNT1_H = 5'h01;
    localparam logic [4:0] A_CNT1_L = 5'h02;
    localparam logic [4:0] A_RLD1_H = 5'h03;
    localparam logic [4:0] A_RLD1_L = 5'h04;
    localparam logic [4:0] A_OUT_EN = 5'h05;
    localparam logic [4:0] A_CHAN0 = 5'h06;
    localparam logic [4:0] A_BRK = 5'h0A;
    localparam logic [4:0] A_DUTY0_H = 5'h0B;
    localparam logic [4:0] A_CAP_H = 5'h13;
    localparam logic [4:0] A_CAP_L = 5'h14;
    localparam logic [4:0] A_CTRL2 = 5'h15;
    localparam logic [4:0] A_RLD2_H = 5'h16;
    localparam logic [4:0] A_RLD2_L = 5'h17;
    localparam logic [4:0] A_DT = 5'h18;
    // Control register fields
    localparam int B_CAPF = 6;
    localparam int B_CAPIE = 5;
    localparam int B_CLK_HI = 4;
    localparam int B_CLK_LO = 3;
    localparam int B_OVF = 2;
    localparam int B_OVF_IRQ_EN = 1;
    localparam int B_MATCH_IRQ_EN = 0;
    // Channel status, break, second control and dead-time fields
    localparam int B_INV = 1;
    localparam int B_MATCH = 0;
    localparam int B_BRK_ACT = 5;
    localparam int B_BRK_PEN = 4;
    localparam int B_XFER1 = 0;
    localparam int B_XFER2 = 1;
    localparam int B_DUAL = 2;
    localparam int B_CAPSRC = 3;
    localparam int B_DT_EN = 7;
    localparam logic [7:0] CTRL2_RST = 8'h03;
    localparam logic [6:0] DT_ZERO = 7'h00;
    // Counter clock selection
    localparam logic [1:0] CLK_OFF0 = 2'h0;
    localparam logic [1:0] CLK_SLOWTB = 2'h1;
    localparam logic [1:0] CLK_CPU = 2'h2;
    typedef enum logic [1:0] {
        DT1_LOW = 2'h0,
        DT1_WAIT = 2'h1,
        DT1_HIGH = 2'h2
    } dt1_state_type;
endpackage

/* File: autoreload_pwm_timer_core.sv */
// Twelve-bit dual auto-reload timer with four PWM channels, break and capture
`timescale 1ns/1ps
// Operation
// - Copy preload duty at overflow if transfer enabled
// - Overflow drives wave outputs high
// - Duty match drives wave output low
// - Polarity change applied at overflow if transfer
// - Per-channel enable, disabled pin goes to port
// - Dead time gap between outputs zero and one
// - Dead-time writes take effect after overflow
// - Enabled zero dead time holds reset state
// - Dead-time edge placement for outputs zero, one
// - Break entered by pin or software write
// - Break pattern forced after polarity inverter
// - Break clears counters, reloads, duties, enables
// - Break release hands pins to port
// - Counter one duty match sets match flag
// - Compare on counter one; dual: channels 0,1
// - No compare match for zero duty
// - Capture edge latches counter, sets flag
// - Flag blocks captures; value read clears it
// - Source select picks second capture pin
// - Slow mode divides by 32; wait ignored
// - Halt stops; active-halt runs only on timebase
// - Overflow restarts counter one from reload
// - Clock select: off, timebase, CPU clock
// - Dual mode runs channels 2,3 from counter two
module autoreload_pwm_timer_core #(
    parameter int NCH = 4
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic timebase_tick_i,
    input wire logic slow_mode_i,
    input wire logic halt_mode_i,
    input wire logic active_halt_i,
    input wire logic brk_pin_n_i,
    input wire logic capture_pin_i,
    input wire logic lite_capture_pin_i,
    output logic [3:0] wave_out_o,
    output logic [3:0] wave_oe_o,
    output logic ovf_irq_o,
    output logic cap_cmp_irq_o
);
    localparam logic [11:0] MAXV = autoreload_pwm_pkg::CNT_MAX;
    localparam logic [11:0] ZERO = autoreload_pwm_pkg::CNT_RST;

    // Two-flop synchronisers for the pins, third stage for edge detect
    logic [2:0] sync1_q, sync2_q;
    logic cap_last_q;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
        end else begin
            sync1_q <= {lite_capture_pin_i, capture_pin_i, brk_pin_n_i};
            sync2_q <= sync1_q;
        end
    end

    logic [7:0] ctrl_q, ctrl2_q, brk_q, dt_reg_q, dt_act_q, rdata_q;
    logic [3:0] out_en_q, inv_pre_q, inv_act_q, match_q, raw_q, wave_q;
    logic [11:0] cnt1_q, cnt2_q, rld1_q, rld2_q, cap_q;
    logic [11:0] duty_pre_q [NCH];
    logic [11:0] duty_act_q [NCH];
    logic [autoreload_pwm_pkg::PRE_W-1:0] pre_q;
    logic ovf_flag_q, moved1_q;
    logic brk_on, dual, base_tick, halted, tick, ovf1, ovf2;
    logic cap_sel, cap_edge, rd_ctrl, rd_cap;
    logic [1:0] clk_sel;

    assign brk_on = brk_q[autoreload_pwm_pkg::B_BRK_ACT];
    assign dual = ctrl2_q[autoreload_pwm_pkg::B_DUAL];
    assign clk_sel = ctrl_q[autoreload_pwm_pkg::B_CLK_HI:autoreload_pwm_pkg::B_CLK_LO];

    // Write strobe decode shared by all register processes
    function automatic logic wr_at(input logic [4:0] a);
        wr_at = reg_wr_i && (reg_addr_i == a);
    endfunction

    // Counter clock source and power-mode gating
    always_comb begin
        case (clk_sel)
            autoreload_pwm_pkg::CLK_CPU: base_tick = 1'b1;
            autoreload_pwm_pkg::CLK_SLOWTB: base_tick = timebase_tick_i;
            default: base_tick = 1'b0;
        endcase
    end
    // Active-halt keeps running only on the slow timebase with overflow irq
    assign halted = halt_mode_i || (active_halt_i && !((clk_sel == autoreload_pwm_pkg::CLK_SLOWTB)
        && ctrl_q[autoreload_pwm_pkg::B_OVF_IRQ_EN]));
    assign tick = base_tick && !halted && !brk_on
        && (!slow_mode_i || pre_q == autoreload_pwm_pkg::PRE_LAST);
    assign ovf1 = tick && (cnt1_q == MAXV);
    assign ovf2 = tick && dual && (cnt2_q == MAXV);

    // Slow-mode prescaler, advanced on each source tick while not halted
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !slow_mode_i) begin
            pre_q <= '0;
        end else if (base_tick && !halted) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Counters restart from their reload value; break clears and stops them
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || brk_on) begin
            cnt1_q <= ZERO;
            cnt2_q <= ZERO;
            moved1_q <= 1'b0;
        end else begin
            moved1_q <= tick;
            if (tick) cnt1_q <= ovf1 ? rld1_q : cnt1_q + 1'b1;
            if (tick && dual) cnt2_q <= ovf2 ? rld2_q : cnt2_q + 1'b1;
        end
    end

    // Control register with overflow flag; a new overflow beats a read clear
    assign rd_ctrl = reg_rd_i && (reg_addr_i == autoreload_pwm_pkg::A_CTRL);
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl_q <= 8'h00;
            ovf_flag_q <= 1'b0;
        end else begin
            if (wr_at(autoreload_pwm_pkg::A_CTRL)) ctrl_q <= reg_wdata_i & 8'h3B;
            if (ovf1) ovf_flag_q <= 1'b1;
            else if (rd_ctrl) ovf_flag_q <= 1'b0;
        end
    end

    // Second control, dead-time buffer and break control
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl2_q <= autoreload_pwm_pkg::CTRL2_RST;
            dt_reg_q <= 8'h00;
            dt_act_q <= 8'h00;
            brk_q <= 8'h00;
        end else begin
            if (wr_at(autoreload_pwm_pkg::A_CTRL2)) ctrl2_q <= reg_wdata_i & 8'h0F;
            if (wr_at(autoreload_pwm_pkg::A_DT)) dt_reg_q <= reg_wdata_i;
            // Avoids distorting the cycle already in progress
            if (ovf1) dt_act_q <= dt_reg_q;
            if (wr_at(autoreload_pwm_pkg::A_BRK)) brk_q <= reg_wdata_i & 8'h3F;
            // Pin low wins over a simultaneous software clear
            if (brk_q[autoreload_pwm_pkg::B_BRK_PEN] && !sync2_q[0]) begin
                brk_q[autoreload_pwm_pkg::B_BRK_ACT] <= 1'b1;
            end
        end
    end

    // Reload values and output enables, all wiped by break
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || brk_on) begin
            rld1_q <= ZERO;
            rld2_q <= ZERO;
            out_en_q <= 4'h0;
        end else begin
            if (wr_at(autoreload_pwm_pkg::A_RLD1_H)) rld1_q[11:8] <= reg_wdata_i[3:0];
            if (wr_at(autoreload_pwm_pkg::A_RLD1_L)) rld1_q[7:0] <= reg_wdata_i;
            if (wr_at(autoreload_pwm_pkg::A_RLD2_H)) rld2_q[11:8] <= reg_wdata_i[3:0];
            if (wr_at(autoreload_pwm_pkg::A_RLD2_L)) rld2_q[7:0] <= reg_wdata_i;
            if (wr_at(autoreload_pwm_pkg::A_OUT_EN)) out_en_q <= reg_wdata_i[3:0];
        end
    end

    // Per-channel duty, polarity, compare and waveform
    logic [3:0] dt_pre;
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            localparam logic [4:0] A_ST = autoreload_pwm_pkg::A_CHAN0 + 5'(i);
            localparam logic [4:0] A_DH = autoreload_pwm_pkg::A_DUTY0_H + 5'(2 * i);
            localparam logic [4:0] A_DL = A_DH + 5'h01;
            logic on2, ch_ovf, ch_xfer, ch_match;
            logic [11:0] ch_cnt;
            assign on2 = (i >= 2) && dual;
            assign ch_ovf = on2 ? ovf2 : ovf1;
            assign ch_xfer = ctrl2_q[on2 ? autoreload_pwm_pkg::B_XFER2
                : autoreload_pwm_pkg::B_XFER1];
            assign ch_cnt = on2 ? cnt2_q : cnt1_q;
            // Output compare only on counter one, never on a zero duty
            assign ch_match = moved1_q && (cnt1_q == duty_act_q[i])
                && (duty_act_q[i] != ZERO) && (i < 2 || !dual);

            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i || brk_on) begin
                    duty_pre_q[i] <= ZERO;
                    duty_act_q[i] <= ZERO;
                end else begin
                    if (wr_at(A_DH)) duty_pre_q[i][11:8] <= reg_wdata_i[3:0];
                    if (wr_at(A_DL)) duty_pre_q[i][7:0] <= reg_wdata_i;
                    if (ch_ovf && ch_xfer) duty_act_q[i] <= duty_pre_q[i];
                end
            end

            // Without transfer enable the inversion applies at once
            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    inv_pre_q[i] <= 1'b0;
                    inv_act_q[i] <= 1'b0;
                    match_q[i] <= 1'b0;
                end else begin
                    if (wr_at(A_ST)) inv_pre_q[i] <= reg_wdata_i[autoreload_pwm_pkg::B_INV];
                    if (!ch_xfer || ch_ovf) inv_act_q[i] <= inv_pre_q[i];
                    if (ch_match) match_q[i] <= 1'b1;
                    else if (reg_rd_i && reg_addr_i == A_ST) match_q[i] <= 1'b0;
                end
            end

            // Raw wave: high from overflow, low as the count steps onto the duty
            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i || brk_on) raw_q[i] <= 1'b0;
                else if (ch_ovf) raw_q[i] <= 1'b1;
                else if (tick && ch_cnt + 12'h001 == duty_act_q[i]) raw_q[i] <= 1'b0;
            end
        end
    endgenerate

    // Dead-time generator for the half-bridge pair, in counter-one ticks
    autoreload_pwm_pkg::dt1_state_type dt1_q;
    logic [6:0] dt0_cnt_q, dt1_cnt_q, dt_len;
    logic dt_on, dt_bad;
    assign dt_len = dt_act_q[6:0];
    assign dt_bad = dt_act_q[autoreload_pwm_pkg::B_DT_EN]
        && (dt_len == autoreload_pwm_pkg::DT_ZERO);
    assign dt_on = dt_act_q[autoreload_pwm_pkg::B_DT_EN] && !dt_bad;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || brk_on) dt0_cnt_q <= 7'h00;
        else if (ovf1) dt0_cnt_q <= dt_len;
        else if (tick && dt0_cnt_q != 7'h00) dt0_cnt_q <= dt0_cnt_q - 1'b1;
    end
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || brk_on) begin
            dt1_q <= autoreload_pwm_pkg::DT1_LOW;
            dt1_cnt_q <= 7'h00;
        end else if (ovf1) begin
            dt1_q <= autoreload_pwm_pkg::DT1_LOW;
        end else begin
            case (dt1_q)
                autoreload_pwm_pkg::DT1_LOW: begin
                    if (raw_q[0] && tick && cnt1_q + 12'h001 == duty_act_q[0]) begin
                        dt1_q <= autoreload_pwm_pkg::DT1_WAIT;
                        dt1_cnt_q <= dt_len;
                    end
                end
                autoreload_pwm_pkg::DT1_WAIT: begin
                    if (tick && dt1_cnt_q <= 7'h01) dt1_q <= autoreload_pwm_pkg::DT1_HIGH;
                    else if (tick) dt1_cnt_q <= dt1_cnt_q - 1'b1;
                end
                autoreload_pwm_pkg::DT1_HIGH: dt1_q <= autoreload_pwm_pkg::DT1_HIGH;
                default: dt1_q <= autoreload_pwm_pkg::DT1_LOW;
            endcase
        end
    end

    // Output stage: dead time, then polarity, then break pattern on top
    always_comb begin
        dt_pre = raw_q;
        if (dt_on) begin
            dt_pre[0] = raw_q[0] && (dt0_cnt_q == 7'h00);
            dt_pre[1] = (dt1_q == autoreload_pwm_pkg::DT1_HIGH);
        end
        if (dt_bad) begin
            dt_pre = 4'h0;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wave_q <= 4'h0;
        end else if (brk_on) begin
            wave_q <= brk_q[3:0];
        end else begin
            wave_q <= dt_pre ^ inv_act_q;
        end
    end
    assign wave_out_o = wave_q;
    // After break release the cleared enables return pins to the port
    assign wave_oe_o = out_en_q | {4{brk_on}};

    // Input capture; the flag blocks later edges until a value read
    assign cap_sel = ctrl2_q[autoreload_pwm_pkg::B_CAPSRC] ? sync2_q[2] : sync2_q[1];
    assign cap_edge = cap_sel != cap_last_q;
    assign rd_cap = reg_rd_i && (reg_addr_i == autoreload_pwm_pkg::A_CAP_H
        || reg_addr_i == autoreload_pwm_pkg::A_CAP_L);
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) cap_last_q <= 1'b1;
        else cap_last_q <= cap_sel;
    end
    logic capf_q;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            capf_q <= 1'b0;
        end else if (cap_edge && !capf_q) begin
            capf_q <= 1'b1;
        end else if (rd_cap && capf_q) begin
            capf_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cap_q <= ZERO;
        end else if (cap_edge && !capf_q) begin
            cap_q <= cnt1_q;
        end
    end

    // Request lines for the system interrupt controller
    assign ovf_irq_o = ovf_flag_q && ctrl_q[autoreload_pwm_pkg::B_OVF_IRQ_EN];
    assign cap_cmp_irq_o = (capf_q && ctrl_q[autoreload_pwm_pkg::B_CAPIE])
        || ((|match_q) && ctrl_q[autoreload_pwm_pkg::B_MATCH_IRQ_EN]);

    // Read data registered, valid the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                autoreload_pwm_pkg::A_CTRL: rdata_q <= {1'b0, capf_q, ctrl_q[5:3],
                    ovf_flag_q, ctrl_q[1:0]};
                autoreload_pwm_pkg::A_CNT1_H: rdata_q <= {4'h0, cnt1_q[11:8]};
                autoreload_pwm_pkg::A_CNT1_L: rdata_q <= cnt1_q[7:0];
                autoreload_pwm_pkg::A_RLD1_H: rdata_q <= {4'h0, rld1_q[11:8]};
                autoreload_pwm_pkg::A_RLD1_L: rdata_q <= rld1_q[7:0];
                autoreload_pwm_pkg::A_OUT_EN: rdata_q <= {4'h0, out_en_q};
                autoreload_pwm_pkg::A_BRK: rdata_q <= brk_q;
                autoreload_pwm_pkg::A_CAP_H: rdata_q <= {4'h0, cap_q[11:8]};
                autoreload_pwm_pkg::A_CAP_L: rdata_q <= cap_q[7:0];
                autoreload_pwm_pkg::A_CTRL2: rdata_q <= ctrl2_q;
                autoreload_pwm_pkg::A_RLD2_H: rdata_q <= {4'h0, rld2_q[11:8]};
                autoreload_pwm_pkg::A_RLD2_L: rdata_q <= rld2_q[7:0];
                autoreload_pwm_pkg::A_DT: rdata_q <= dt_reg_q;
                default: rdata_q <= chan_or_duty(reg_addr_i);
            endcase
        end
    end
    assign reg_rdata_o = rdata_q;

    // Channel status and preload duty read-back; unmapped reads zero
    function automatic logic [7:0] chan_or_duty(input logic [4:0] a);
        logic [4:0] d;
        d = a - autoreload_pwm_pkg::A_DUTY0_H;
        chan_or_duty = 8'h00;
        for (int k = 0; k < NCH; k++) begin
            if (a == autoreload_pwm_pkg::A_CHAN0 + 5'(k)) begin
                chan_or_duty = {6'h00, inv_pre_q[k], match_q[k]};
            end
            if (a >= autoreload_pwm_pkg::A_DUTY0_H && d[4:1] == 4'(k)) begin
                chan_or_duty = d[0] ? duty_pre_q[k][7:0] : {4'h0, duty_pre_q[k][11:8]};
            end
        end
    endfunction

    // Checks on the timer behaviour
    sequence s_brk_enter;
        brk_on && !$past(brk_on);
    endsequence
    sequence s_ovf1;
        ovf1 && !brk_on;
    endsequence
    a_ovf_reload: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf1 ##1 !brk_on |-> cnt1_q == $past(rld1_q)) else $error("reload missed");
    a_wave_high: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf1 ##1 !brk_on |-> raw_q[0]) else $error("wave not high after overflow");
    a_duty_xfer: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf1 ##0 ctrl2_q[autoreload_pwm_pkg::B_XFER1] ##1 !brk_on
        |-> duty_act_q[0] == $past(duty_pre_q[0]))
        else $error("duty not transferred");
    a_break_pattern: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        brk_on ##1 brk_on |-> wave_out_o == $past(brk_q[3:0])) else $error("pattern lost");
    a_break_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_brk_enter ##1 brk_on |-> cnt1_q == ZERO && out_en_q == 4'h0 && rld1_q == ZERO)
        else $error("break did not clear");
    a_cap_latch: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        cap_edge && !capf_q |=> capf_q && cap_q == $past(cnt1_q)) else $error("capture lost");
    a_cap_block: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        capf_q && !rd_cap |=> capf_q && $stable(cap_q)) else $error("capture not blocked");
    a_zero_no_match: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        duty_act_q[0] == ZERO && !match_q[0] |=> !match_q[0]) else $error("zero duty match");
    a_dt_zero_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        dt_bad && !brk_on |=> wave_out_o == $past(inv_act_q)) else $error("dead time zero");
endmodule

/* File: autoreload_pwm_timer_core_tb_top.sv */
// Self-checking bench for the auto-reload PWM timer core
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module autoreload_pwm_timer_core_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt = 1'b0;
    logic brk_n = 1'b1, cap = 1'b1, lcap = 1'b1, slow = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, d1, d2;
    logic [3:0] wave, oe;
    int error_cnt = 0, tests_run = 0, cyc = 0, ovl, n;
    autoreload_pwm_timer_core u_autoreload_pwm_timer_core (.clk_sys_i(clk), .reset_n_i(rst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .timebase_tick_i(1'b0), .slow_mode_i(slow), .halt_mode_i(halt),
        .active_halt_i(1'b0), .brk_pin_n_i(brk_n), .capture_pin_i(cap),
        .lite_capture_pin_i(lcap), .wave_out_o(wave), .wave_oe_o(oe), .ovf_irq_o(),
        .cap_cmp_irq_o());
    half_bridge_stage u_half_bridge_stage (.clk_sys_i(clk), .high_side_i(wave[0] & oe[0]),
        .low_side_i(wave[1] & oe[1]), .overlap_cnt_o(ovl));
    // Free-running 20 MHz clock
    always #25 clk = ~clk;
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One-cycle bus strobes launched just after the edge
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // Settle past an overflow, then count high cycles over one 256-cycle period
    task automatic measure(input int ch, output int cnt);
        repeat (300) @(posedge clk);
        cnt = 0;
        repeat (256) begin
            @(negedge clk);
            cnt += int'(wave[ch]);
        end
    endtask
    task automatic t_reset_state();
        rreg(autoreload_pwm_pkg::A_CTRL2, d1);
        `CHK(d1, 8'h03)
        rreg(autoreload_pwm_pkg::A_OUT_EN, d1);
        `CHK(d1, 8'h00)
    endtask
    task automatic t_pwm_xfer();
        // Reload F00 gives a 256-cycle period; duty F80 is half of it
        wreg(autoreload_pwm_pkg::A_RLD1_H, 8'h0F);
        wreg(autoreload_pwm_pkg::A_DUTY0_H, 8'h0F);
        wreg(5'h0C, 8'h80);
        wreg(autoreload_pwm_pkg::A_OUT_EN, 8'h01);
        wreg(autoreload_pwm_pkg::A_CTRL, 8'h10);
        repeat (4096) @(posedge clk); // First overflow only after counting up from zero
        measure(0, n);
        `CHK(n, 128)
        `CHK(oe, 4'h1)
        wreg(autoreload_pwm_pkg::A_CTRL2, 8'h02);
        wreg(5'h0C, 8'hC0);
        measure(0, n);
        `CHK(n, 128)
        wreg(autoreload_pwm_pkg::A_CTRL2, 8'h03);
        measure(0, n);
        `CHK(n, 192)
    endtask
    task automatic t_match_flags();
        rreg(autoreload_pwm_pkg::A_CHAN0, d1);
        `CHK(d1[0], 1'b1)
        rreg(autoreload_pwm_pkg::A_CHAN0, d1);
        `CHK(d1[0], 1'b0)
        rreg(5'h07, d1);
        `CHK(d1[0], 1'b0)
    endtask
    task automatic t_deadtime();
        int o0;
        o0 = ovl;
        wreg(autoreload_pwm_pkg::A_DT, 8'h8A);
        measure(0, n);
        `CHK(n, 182)
        // Low side joins only once the gap is in force
        wreg(autoreload_pwm_pkg::A_OUT_EN, 8'h03);
        measure(1, n);
        `CHK(n, 54)
        `CHK(ovl, o0)
        wreg(autoreload_pwm_pkg::A_DT, 8'h80);
        measure(0, n);
        `CHK(n, 0)
        wreg(autoreload_pwm_pkg::A_DT, 8'h00);
        wreg(autoreload_pwm_pkg::A_CHAN0, 8'h02);
        measure(0, n);
        `CHK(n, 64)
    endtask
    task automatic t_capture_halt();
        rreg(autoreload_pwm_pkg::A_CAP_H, d1);
        cap <= 1'b0;
        rreg(autoreload_pwm_pkg::A_CNT1_L, d2);
        repeat (40) @(posedge clk);
        cap <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(autoreload_pwm_pkg::A_CTRL, d1);
        `CHK(d1[6], 1'b1)
        rreg(autoreload_pwm_pkg::A_CAP_L, d1);
        `CHK((d1 - d2) < 8'h08, 1'b1)
        rreg(autoreload_pwm_pkg::A_CTRL, d1);
        `CHK(d1[6], 1'b0)
        // Second capture pin through the source select
        wreg(autoreload_pwm_pkg::A_CTRL2, 8'h0B);
        lcap <= 1'b0;
        repeat (6) @(posedge clk);
        rreg(autoreload_pwm_pkg::A_CTRL, d1);
        `CHK(d1[6], 1'b1)
        rreg(autoreload_pwm_pkg::A_CAP_H, d1);
        halt <= 1'b1;
        rreg(autoreload_pwm_pkg::A_CNT1_L, d1);
        repeat (20) @(posedge clk);
        rreg(autoreload_pwm_pkg::A_CNT1_L, d2);
        `CHK(d2, d1)
        halt <= 1'b0;
        // Slow mode: one count per 32 source ticks
        slow <= 1'b1;
        rreg(autoreload_pwm_pkg::A_CNT1_L, d1);
        repeat (64) @(posedge clk);
        rreg(autoreload_pwm_pkg::A_CNT1_L, d2);
        `CHK(d2 - d1, 8'h02)
        slow <= 1'b0;
    endtask
    task automatic t_break();
        wreg(autoreload_pwm_pkg::A_BRK, 8'h25);
        repeat (4) @(posedge clk);
        `CHK(wave, 4'h5)
        `CHK(oe, 4'hF)
        rreg(autoreload_pwm_pkg::A_CNT1_L, d1);
        `CHK(d1, 8'h00)
        rreg(autoreload_pwm_pkg::A_RLD1_H, d1);
        `CHK(d1, 8'h00)
        rreg(autoreload_pwm_pkg::A_DUTY0_H, d1);
        `CHK(d1, 8'h00)
        wreg(autoreload_pwm_pkg::A_BRK, 8'h10);
        repeat (3) @(posedge clk);
        `CHK(oe, 4'h0)
        brk_n <= 1'b0;
        repeat (6) @(posedge clk);
        rreg(autoreload_pwm_pkg::A_BRK, d1);
        `CHK(d1, 8'h30)
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_state();
        t_pwm_xfer();
        t_match_flags();
        t_deadtime();
        t_capture_halt();
        t_break();
        close_out();
    end
endmodule

/* File: half_bridge_stage.sv */
// Half-bridge power stage model that counts shoot-through cycles
`timescale 1ns/1ps
module half_bridge_stage (
    input wire logic clk_sys_i,
    input wire logic high_side_i,
    input wire logic low_side_i,
    output int overlap_cnt_o
);
    // Both switches on at once shorts the supply; count every such cycle
    initial overlap_cnt_o = 0;
    always @(posedge clk_sys_i) begin
        if (high_side_i === 1'b1 && low_side_i === 1'b1) begin
            overlap_cnt_o <= overlap_cnt_o + 1;
        end
    end
endmodule
